// ---- hw/ecs_pkg.sv ----
// Operation
// RULE1 - Primary pointer: 16-bit, byte or word access
// RULE2 - Status bit 7 is carry/borrow
// RULE3 - Status bit 6 is half carry/borrow
// RULE4 - Status bits 5 and 1 are user flags
// RULE5 - Status bits 4-3 pick register bank
// RULE6 - Status bit 2 is overflow
// RULE7 - Status bit 0 is accumulator odd parity
// RULE8 - Reset leaves multiply and divide 8-bit
// RULE9 - 8-bit multiply: low to A, high to B
// RULE10 - 16-bit multiply: low A, middle B, high aux
// RULE11 - 8-bit divide: quotient A, remainder B
// RULE12 - 16-bit divide: quotient low A, high aux
// RULE13 - Aux byte otherwise a plain scratch register
// RULE14 - Select bit 0 picks active data pointer
// RULE15 - Select bit 6 picks special register bank
// RULE16 - Lower RAM 00H-7FH direct and indirect
// RULE17 - Upper RAM 80H-FFH indirect only
// RULE18 - Direct 80H-FFH goes to special registers
// RULE19 - External RAM 000H-4FFH, 1280 bytes, pointer-reachable
// RULE20 - Indirect external moves use page register
// RULE21 - Unimplemented select/page bits read zero
package ecs_pkg;
  localparam logic [7:0] ADDR_SELECT = 8'h86;
  localparam logic [7:0] ADDR_PTR0_LO = 8'h82;
  localparam logic [7:0] ADDR_PTR0_HI = 8'h83;
  localparam logic [7:0] ADDR_PTR1_LO = 8'h84;
  localparam logic [7:0] ADDR_PTR1_HI = 8'h85;
  localparam logic [7:0] ADDR_STATUS = 8'hd0;
  localparam logic [7:0] ADDR_AUX = 8'hf1;
  localparam logic [7:0] ADDR_PAGE = 8'hf7;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam int ST_CY = 7;
  localparam int ST_AC = 6;
  localparam int ST_UA = 5;
  localparam int ST_RS_HI = 4;
  localparam int ST_RS_LO = 3;
  localparam int ST_OV = 2;
  localparam int ST_UB = 1;
  localparam int ST_P = 0;
  localparam int SEL_BANK = 6;
  localparam int SEL_DIV = 3;
  localparam int SEL_MUL = 2;
  localparam int SEL_DPS = 0;
  localparam logic [7:0] SEL_MASK = 8'h4d;
  localparam logic [7:0] PAGE_MASK = 8'h7f;
  localparam logic [7:0] STATUS_WR_MASK = 8'hfe;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] XRAM_LAST = 16'h04ff;
  localparam logic [2:0] BANK_LOW_BITS = 3'h0;
  typedef enum logic [2:0] {
    OP_NONE = 3'b001,
    OP_MUL = 3'b010,
    OP_DIV = 3'b100
  } ecs_op_type;
endpackage

// ---- hw/ecs_md_if.sv ----
`timescale 1ns/100ps
interface ecs_md_if;
  logic [7:0] acc;
  logic [7:0] bop;
  logic [7:0] aux;
  logic wide;
  logic [7:0] res_a;
  logic [7:0] res_b;
  logic [7:0] res_aux;
  logic ov;
  modport core (output acc, bop, aux, wide, input res_a, res_b, res_aux, ov);
  modport unit (input acc, bop, aux, wide, output res_a, res_b, res_aux, ov);
endinterface

// ---- hw/ecs_muldiv.sv ----
`timescale 1ns/100ps
module ecs_mul (
  ecs_md_if.unit md
);
  logic [23:0] prod;
  always_comb begin
    prod = {8'h00, (md.wide ? md.aux : 8'h00), md.acc} * {16'h0000, md.bop};
    md.res_a = prod[7:0];
    md.res_b = prod[15:8];
    md.res_aux = md.wide ? prod[23:16] : md.aux;
    md.ov = md.wide ? (prod[23:16] != 8'h00) : (prod[15:8] != 8'h00);
  end
endmodule

module ecs_div (
  ecs_md_if.unit md
);
  logic [15:0] num;
  logic [15:0] quo;
  logic [15:0] rem;
  always_comb begin
    num = {(md.wide ? md.aux : 8'h00), md.acc};
    quo = 16'h0000;
    rem = 16'h0000;
    if (md.bop != 8'h00) begin
      quo = num / {8'h00, md.bop};
      rem = num % {8'h00, md.bop};
    end
    md.res_a = quo[7:0];
    md.res_b = rem[7:0];
    md.res_aux = md.wide ? quo[15:8] : md.aux;
    md.ov = (md.bop == 8'h00);
  end
endmodule

// ---- hw/ecs_core.sv ----
`timescale 1ns/100ps
module ecs_core
  import ecs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Special register access
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Sixteen-bit pointer access by instructions
  input wire logic ptr_wr,
  input wire logic [15:0] ptr_wdata,
  output logic [15:0] active_pointer,
  // ALU flags and multiply/divide operands
  input wire logic flag_wr,
  input wire logic carry_in,
  input wire logic half_carry_in,
  input wire logic overflow_in,
  input wire logic [7:0] acc_value,
  input wire logic [7:0] b_value,
  input wire logic op_mul,
  input wire logic op_div,
  output logic [7:0] md_acc_out,
  output logic [7:0] md_b_out,
  output logic md_done,
  // Internal memory routing
  input wire logic [7:0] data_addr,
  input wire logic data_indirect,
  output logic sel_sfr,
  output logic sel_upper_ram,
  output logic sel_lower_ram,
  output logic sfr_bank,
  output logic [4:0] bank_base,
  // External data moves
  input wire logic xmove,
  input wire logic xmove_by_ptr,
  input wire logic [7:0] xmove_ri,
  output logic [15:0] xram_addr,
  output logic xram_sel
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] select;
    logic [7:0] page;
    logic [7:0] aux;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [7:0] rdata;
    logic [15:0] act_ptr;
    logic [7:0] md_a;
    logic [7:0] md_b;
    logic md_done;
    logic s_sfr;
    logic s_up;
    logic s_lo;
    logic [4:0] base;
    logic [15:0] xaddr;
    logic xsel;
  } ecs_state_type;

  ecs_state_type cur_ff;
  ecs_state_type nxt_ff;
  ecs_op_type op;

  ecs_md_if mul_bus ();
  ecs_md_if div_bus ();

  assign mul_bus.acc = acc_value;
  assign mul_bus.bop = b_value;
  assign mul_bus.aux = cur_ff.aux;
  assign mul_bus.wide = cur_ff.select[SEL_MUL];
  assign div_bus.acc = acc_value;
  assign div_bus.bop = b_value;
  assign div_bus.aux = cur_ff.aux;
  assign div_bus.wide = cur_ff.select[SEL_DIV];

  ecs_mul u_mul (.md(mul_bus)); // see RULE9 see RULE10
  ecs_div u_div (.md(div_bus)); // see RULE11 see RULE12

  always_comb begin
    if (op_mul) begin
      op = OP_MUL;
    end else if (op_div) begin
      op = OP_DIV;
    end else begin
      op = OP_NONE;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [15:0] ptr_sel;
    logic [7:0] rd;
    ptr_sel = cur_ff.select[SEL_DPS] ? cur_ff.ptr1 : cur_ff.ptr0;
    rd = RST_BYTE;
    nxt_ff = cur_ff;
    nxt_ff.md_done = 1'b0;
    // Flags from the ALU; user bits and bank bits stay put
    if (flag_wr) begin
      nxt_ff.status[ST_CY] = carry_in; // see RULE2
      nxt_ff.status[ST_AC] = half_carry_in; // see RULE3
      nxt_ff.status[ST_OV] = overflow_in; // see RULE6
    end
    case (op)
      OP_MUL: begin
        nxt_ff.md_a = mul_bus.res_a;
        nxt_ff.md_b = mul_bus.res_b;
        nxt_ff.aux = mul_bus.res_aux; // see RULE10
        nxt_ff.status[ST_CY] = 1'b0;
        nxt_ff.status[ST_OV] = mul_bus.ov;
        nxt_ff.md_done = 1'b1;
      end
      OP_DIV: begin
        nxt_ff.md_a = div_bus.res_a;
        nxt_ff.md_b = div_bus.res_b;
        nxt_ff.aux = div_bus.res_aux; // see RULE12
        nxt_ff.status[ST_CY] = 1'b0;
        nxt_ff.status[ST_OV] = div_bus.ov;
        nxt_ff.md_done = 1'b1;
      end
      default: begin
      end
    endcase
    // Sixteen-bit write lands in whichever pointer is active
    if (ptr_wr) begin
      if (cur_ff.select[SEL_DPS]) begin // see RULE14
        nxt_ff.ptr1 = ptr_wdata;
      end else begin
        nxt_ff.ptr0 = ptr_wdata; // see RULE1
      end
    end
    // Byte writes take priority over the word path, the later instruction wins
    if (sfr_wr) begin
      if (sfr_addr == ADDR_SELECT) begin
        nxt_ff.select = sfr_wdata & SEL_MASK; // see RULE21
      end else if (sfr_addr == ADDR_PAGE) begin
        nxt_ff.page = sfr_wdata & PAGE_MASK; // see RULE21
      end else if (sfr_addr == ADDR_STATUS) begin
        // Parity stays hardware owned
        nxt_ff.status = (sfr_wdata & STATUS_WR_MASK) | (cur_ff.status & ~STATUS_WR_MASK); // see RULE4
      end else if (sfr_addr == ADDR_AUX) begin
        nxt_ff.aux = sfr_wdata; // see RULE13
      end else if (sfr_addr == ADDR_PTR0_LO) begin
        nxt_ff.ptr0[7:0] = sfr_wdata; // see RULE1
      end else if (sfr_addr == ADDR_PTR0_HI) begin
        nxt_ff.ptr0[15:8] = sfr_wdata;
      end else if (sfr_addr == ADDR_PTR1_LO) begin
        nxt_ff.ptr1[7:0] = sfr_wdata;
      end else if (sfr_addr == ADDR_PTR1_HI) begin
        nxt_ff.ptr1[15:8] = sfr_wdata;
      end
    end
    nxt_ff.status[ST_P] = ^acc_value; // see RULE7
    // Read data, registered
    if (sfr_addr == ADDR_SELECT) begin
      rd = cur_ff.select & SEL_MASK;
    end else if (sfr_addr == ADDR_PAGE) begin
      rd = cur_ff.page & PAGE_MASK;
    end else if (sfr_addr == ADDR_STATUS) begin
      rd = cur_ff.status;
    end else if (sfr_addr == ADDR_AUX) begin
      rd = cur_ff.aux;
    end else if (sfr_addr == ADDR_PTR0_LO) begin
      rd = cur_ff.ptr0[7:0];
    end else if (sfr_addr == ADDR_PTR0_HI) begin
      rd = cur_ff.ptr0[15:8];
    end else if (sfr_addr == ADDR_PTR1_LO) begin
      rd = cur_ff.ptr1[7:0];
    end else if (sfr_addr == ADDR_PTR1_HI) begin
      rd = cur_ff.ptr1[15:8];
    end else begin
      rd = RST_BYTE;
    end
    nxt_ff.rdata = rd;
    nxt_ff.act_ptr = ptr_sel; // see RULE14
    // Internal memory split by address and mode
    nxt_ff.s_lo = (data_addr < UPPER_BASE); // see RULE16
    nxt_ff.s_up = (data_addr >= UPPER_BASE) && data_indirect; // see RULE17
    nxt_ff.s_sfr = (data_addr >= UPPER_BASE) && !data_indirect; // see RULE18
    nxt_ff.base = {cur_ff.status[ST_RS_HI:ST_RS_LO], BANK_LOW_BITS}; // see RULE5
    // External addressing: pointer covers all, @Ri uses page for high byte
    if (xmove_by_ptr) begin
      nxt_ff.xaddr = ptr_sel; // see RULE19
    end else begin
      nxt_ff.xaddr = {cur_ff.page & PAGE_MASK, xmove_ri}; // see RULE20
    end
    nxt_ff.xsel = xmove && (nxt_ff.xaddr <= XRAM_LAST); // see RULE19
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cur_ff <= '0; // see RULE8
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sfr_rdata = cur_ff.rdata;
  assign active_pointer = cur_ff.act_ptr;
  assign md_acc_out = cur_ff.md_a;
  assign md_b_out = cur_ff.md_b;
  assign md_done = cur_ff.md_done;
  assign sel_sfr = cur_ff.s_sfr;
  assign sel_upper_ram = cur_ff.s_up;
  assign sel_lower_ram = cur_ff.s_lo;
  assign sfr_bank = cur_ff.select[SEL_BANK]; // see RULE15
  assign bank_base = cur_ff.base;
  assign xram_addr = cur_ff.xaddr;
  assign xram_sel = cur_ff.xsel;

  // ****************************************
  // Checks
  // ****************************************
  a_mul_narrow: assert property (@(posedge sys_clk) disable iff (srst) // see RULE9
    (op_mul && !cur_ff.select[SEL_MUL]) |=> ({md_b_out, md_acc_out} ==
      $past(acc_value) * $past(b_value)))
    else $error("narrow multiply result wrong");
  a_mul_wide_aux: assert property (@(posedge sys_clk) disable iff (srst) // see RULE10
    (op_mul && cur_ff.select[SEL_MUL] && !sfr_wr) |=>
      ({cur_ff.aux, md_b_out, md_acc_out} ==
       {$past(cur_ff.aux), $past(acc_value)} * $past(b_value)))
    else $error("wide multiply result wrong");
  a_div_narrow: assert property (@(posedge sys_clk) disable iff (srst) // see RULE11
    (op_div && !op_mul && !cur_ff.select[SEL_DIV] && b_value != 8'h00) |=>
      (md_acc_out == $past(acc_value) / $past(b_value)))
    else $error("narrow divide quotient wrong");
  a_aux_hold: assert property (@(posedge sys_clk) disable iff (srst) // see RULE13
    (!op_mul && !op_div && !sfr_wr) |=> $stable(cur_ff.aux))
    else $error("aux byte changed implicitly");
  a_parity_acc: assert property (@(posedge sys_clk) disable iff (srst) // see RULE7
    1'b1 |=> (cur_ff.status[ST_P] == ^$past(acc_value)))
    else $error("parity flag wrong");
  a_sel_zero: assert property (@(posedge sys_clk) disable iff (srst) // see RULE21
    (cur_ff.select & ~SEL_MASK) == 8'h00 && (cur_ff.page & ~PAGE_MASK) == 8'h00)
    else $error("unimplemented bits set");
  a_upper_split: assert property (@(posedge sys_clk) disable iff (srst) // see RULE18
    (data_addr >= UPPER_BASE) |=> (sel_sfr != sel_upper_ram) && !sel_lower_ram)
    else $error("upper address routing wrong");
  a_page_addr: assert property (@(posedge sys_clk) disable iff (srst) // see RULE20
    (!xmove_by_ptr) |=> (xram_addr[15:8] == $past(cur_ff.page)))
    else $error("page byte not used");
  a_reset_narrow: assert property (@(posedge sys_clk) // see RULE8
    srst |=> (cur_ff.select == 8'h00))
    else $error("reset left wide mode");
  a_carry_load: assert property (@(posedge sys_clk) disable iff (srst) // see RULE2
    (flag_wr && !op_mul && !op_div && !(sfr_wr && sfr_addr == ADDR_STATUS)) |=>
      (cur_ff.status[ST_CY] == $past(carry_in)))
    else $error("carry flag not loaded");
  a_half_carry: assert property (@(posedge sys_clk) disable iff (srst) // see RULE3
    (flag_wr && !(sfr_wr && sfr_addr == ADDR_STATUS)) |=>
      (cur_ff.status[ST_AC] == $past(half_carry_in)))
    else $error("half carry flag not loaded");
  a_ovf_load: assert property (@(posedge sys_clk) disable iff (srst) // see RULE6
    (flag_wr && !op_mul && !op_div && !(sfr_wr && sfr_addr == ADDR_STATUS)) |=>
      (cur_ff.status[ST_OV] == $past(overflow_in)))
    else $error("overflow flag not loaded");
  a_user_flags: assert property (@(posedge sys_clk) disable iff (srst) // see RULE4
    !(sfr_wr && sfr_addr == ADDR_STATUS) |=>
      ($stable(cur_ff.status[ST_UA]) && $stable(cur_ff.status[ST_UB])))
    else $error("user flag changed by hardware");
  a_bank_base: assert property (@(posedge sys_clk) disable iff (srst) // see RULE5
    1'b1 |=>
      (bank_base == {$past(cur_ff.status[ST_RS_HI:ST_RS_LO]), BANK_LOW_BITS}))
    else $error("register bank base wrong");
  a_div_wide: assert property (@(posedge sys_clk) disable iff (srst) // see RULE12
    (op_div && !op_mul && cur_ff.select[SEL_DIV] && b_value != 8'h00 && !sfr_wr) |=>
      ({cur_ff.aux, md_acc_out} == {$past(cur_ff.aux), $past(acc_value)} / $past(b_value)))
    else $error("wide divide quotient wrong");
  a_ptr_word: assert property (@(posedge sys_clk) disable iff (srst) // see RULE1
    (ptr_wr && !sfr_wr) |=>
      (($past(cur_ff.select[SEL_DPS]) ? cur_ff.ptr1 : cur_ff.ptr0) == $past(ptr_wdata)))
    else $error("word pointer write lost");
  a_ptr_select: assert property (@(posedge sys_clk) disable iff (srst) // see RULE14
    1'b1 |=> (active_pointer ==
      $past(cur_ff.select[SEL_DPS] ? cur_ff.ptr1 : cur_ff.ptr0)))
    else $error("active pointer wrong");
  a_bank_bit: assert property (@(posedge sys_clk) disable iff (srst) // see RULE15
    (sfr_wr && sfr_addr == ADDR_SELECT) |=>
      (sfr_bank == $past(sfr_wdata[SEL_BANK])))
    else $error("special register bank bit wrong");
  a_lower_split: assert property (@(posedge sys_clk) disable iff (srst) // see RULE16
    (data_addr < UPPER_BASE) |=>
      (sel_lower_ram && !sel_upper_ram && !sel_sfr))
    else $error("lower address routing wrong");
  a_upper_indirect: assert property (@(posedge sys_clk) disable iff (srst) // see RULE17
    (data_addr >= UPPER_BASE && data_indirect) |=>
      (sel_upper_ram && !sel_sfr))
    else $error("indirect upper access not to ram");
  a_xram_ptr: assert property (@(posedge sys_clk) disable iff (srst) // see RULE19
    xmove_by_ptr |=>
      (xram_addr == $past(cur_ff.select[SEL_DPS] ? cur_ff.ptr1 : cur_ff.ptr0)))
    else $error("pointer move address wrong");
  a_xram_sel: assert property (@(posedge sys_clk) disable iff (srst) // see RULE19
    1'b1 |=>
      (xram_sel == ($past(xmove) && (xram_addr <= XRAM_LAST))))
    else $error("external ram select wrong");
endmodule

// ---- testbench/ecs_exec_model.sv ----
`timescale 1ns/100ps
// ****
// Instruction side of the core
// ****
// Every request is launched at a falling edge and held a whole cycle
module ecs_exec_model (
  // Clock
  input wire logic sys_clk,
  // Register and pointer requests
  output logic sfr_wr,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic ptr_wr,
  output logic [15:0] ptr_wdata,
  // Flags and operands
  output logic flag_wr,
  output logic carry_in,
  output logic half_carry_in,
  output logic overflow_in,
  output logic [7:0] acc_value,
  output logic [7:0] b_value,
  output logic op_mul,
  output logic op_div,
  // Memory accesses
  output logic [7:0] data_addr,
  output logic data_indirect,
  output logic xmove,
  output logic xmove_by_ptr,
  output logic [7:0] xmove_ri
);
  initial begin
    {sfr_wr, sfr_addr, sfr_wdata, ptr_wr, ptr_wdata, flag_wr, carry_in} = '0;
    {half_carry_in, overflow_in, acc_value, b_value, op_mul, op_div} = '0;
    {data_addr, data_indirect, xmove, xmove_by_ptr, xmove_ri} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    sfr_addr = a;
  endtask
  // Operands stay put afterwards, as the accumulator would
  task automatic op(input logic m, input logic d, input logic [7:0] a, input logic [7:0] b);
    @(negedge sys_clk);
    acc_value = a;
    b_value = b;
    op_mul = m;
    op_div = d;
    @(negedge sys_clk);
    op_mul = 1'b0;
    op_div = 1'b0;
  endtask
  task automatic flags(input logic c, input logic h, input logic o);
    @(negedge sys_clk);
    {flag_wr, carry_in, half_carry_in, overflow_in} = {1'b1, c, h, o};
    @(negedge sys_clk);
    flag_wr = 1'b0;
  endtask
  task automatic pw(input logic [15:0] v);
    @(negedge sys_clk);
    ptr_wr = 1'b1;
    ptr_wdata = v;
    @(negedge sys_clk);
    ptr_wr = 1'b0;
  endtask
  task automatic route(input logic [7:0] d, input logic i, input logic x, input logic p,
                       input logic [7:0] r);
    @(negedge sys_clk);
    {data_addr, data_indirect, xmove, xmove_by_ptr, xmove_ri} = {d, i, x, p, r};
  endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
module testbench
  import ecs_pkg::*;
;
  typedef struct {int kind; logic [16:0] val;} ecs_note_type;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic look = 1'b0;
  logic sfr_wr, ptr_wr, flag_wr, carry_in, half_carry_in, overflow_in, op_mul, op_div;
  logic data_indirect, xmove, xmove_by_ptr, md_done, sel_sfr, sel_upper_ram, sel_lower_ram;
  logic sfr_bank, xram_sel;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, acc_value, b_value, data_addr, xmove_ri;
  logic [7:0] md_acc_out, md_b_out, a, b, x, v;
  logic [15:0] ptr_wdata, active_pointer, xram_addr, n, q, r;
  logic [23:0] p;
  logic [4:0] bank_base;
  logic [7:0] ad [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
  string names [6] = '{"sfr_rdata", "md_result", "routing", "pointer", "xram", "md_flags"};
  ecs_note_type notes_q [$];
  ecs_note_type nt;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 48284;
  int i;
  always #20 sys_clk = ~sys_clk;
  ecs_core uut (.*);
  ecs_exec_model u_exec (.*);
  function automatic logic [16:0] seen(input int k);
    case (k)
      0: seen = {9'h000, sfr_rdata};
      1: seen = {1'b0, md_acc_out, md_b_out};
      2: seen = {8'h00, sfr_bank, bank_base, sel_sfr, sel_upper_ram, sel_lower_ram};
      3: seen = {1'b0, active_pointer};
      4: seen = {xram_sel, xram_addr};
      default: seen = {9'h000, sfr_rdata & 8'h84};
    endcase
  endfunction
  // ****
  // Result watcher
  // ****
  always @(negedge sys_clk) begin
    if (md_done === 1'b1 || look) begin
      nt = notes_q.pop_front();
      comparisons++;
      if (seen(nt.kind) !== nt.val) begin
        n_mismatch++;
        $display("[FAIL] %s expected %h seen %h", names[nt.kind], nt.val, seen(nt.kind));
      end
    end
  end
  // Registered outputs are looked at two falling edges after the request
  task automatic chk(input int k, input logic [16:0] e);
    notes_q.push_back('{k, e});
    @(negedge sys_clk);
    look <= 1'b1;
    @(negedge sys_clk);
    look <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [7:0] e, input int k);
    u_exec.rd(ad);
    chk(k, {9'h000, e});
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    conclude;
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    rchk(ADDR_SELECT, 8'h00, 0);
    rchk(ADDR_STATUS, 8'h00, 0);
    u_exec.wr(ADDR_SELECT, 8'hff);
    rchk(ADDR_SELECT, SEL_MASK, 0);
    u_exec.wr(ADDR_PAGE, 8'hff);
    rchk(ADDR_PAGE, PAGE_MASK, 0);
    u_exec.wr(ADDR_SELECT, 8'h00);
    $display("test reset and masks done");
    for (i = 0; i < 4; i++) begin
      a = 8'($random(seed));
      v = 8'($random(seed));
      x = 8'($random(seed));
      v[4:3] = i[1:0];
      u_exec.op(1'b0, 1'b0, a, 8'h00);
      u_exec.wr(ADDR_STATUS, v);
      rchk(ADDR_STATUS, {v[7:1], ^a}, 0);
      u_exec.route(8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
      chk(2, {9'h000, v[4:3], 3'h0, 3'h1});
      u_exec.flags(x[0], x[1], x[2]);
      rchk(ADDR_STATUS, {x[0], x[1], v[5:3], x[2], v[1], ^a}, 0);
    end
    $display("test status done");
    for (i = 0; i < 8; i++) begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      x = 8'($random(seed));
      b = (i == 6) ? 8'h00 : (b | 8'h01);
      u_exec.wr(ADDR_AUX, x);
      u_exec.wr(ADDR_SELECT, {4'h0, i[1:0] == 2'h3, i[1:0] == 2'h1, 2'h0});
      n = i[0] ? {x, a} : {8'h00, a};
      p = n * b;
      q = (b == 8'h00) ? 16'h0000 : n / b;
      r = (b == 8'h00) ? 16'h0000 : n % b;
      notes_q.push_back('{1, i[1] ? {1'b0, q[7:0], r[7:0]} : {1'b0, p[7:0], p[15:8]}});
      u_exec.op(!i[1], i[1], a, b);
      rchk(ADDR_AUX, i[0] ? (i[1] ? q[15:8] : p[23:16]) : x, 0);
      if (!i[0]) rchk(ADDR_STATUS, {5'h00, i[1] ? b == 8'h00 : p[15:8] != 8'h00, 2'h0}, 5);
    end
    $display("test multiply divide done");
    // Mid-run reset must drop the wide modes again
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    rchk(ADDR_SELECT, 8'h00, 0);
    a = 8'($random(seed));
    b = 8'($random(seed));
    u_exec.wr(ADDR_SELECT, 8'h00);
    u_exec.wr(ADDR_PTR0_LO, a);
    u_exec.wr(ADDR_PTR0_HI, b);
    chk(3, {1'b0, b, a});
    u_exec.wr(ADDR_PTR1_HI, a);
    u_exec.wr(ADDR_SELECT, 8'h01);
    chk(3, {1'b0, a, 8'h00});
    u_exec.pw(16'h04ff);
    rchk(ADDR_PTR1_LO, 8'hff, 0);
    rchk(ADDR_PTR0_HI, b, 0);
    u_exec.route(8'h00, 1'b0, 1'b1, 1'b1, 8'h00);
    chk(4, {1'b1, 16'h04ff});
    for (i = 4; i < 6; i++) begin
      u_exec.wr(ADDR_PAGE, i[7:0]);
      u_exec.route(8'h00, 1'b0, 1'b1, 1'b0, 8'hff);
      chk(4, {i == 4, i[7:0], 8'hff});
    end
    $display("test pointers and external ram done");
    u_exec.wr(ADDR_SELECT, 8'h40);
    for (i = 0; i < 8; i++) begin
      x = ad[i[2:1]];
      u_exec.route(x, i[0], 1'b0, 1'b0, 8'h00);
      b = x < 8'h80 ? 8'h01 : (i[0] ? 8'h02 : 8'h04);
      chk(2, {8'h00, 1'b1, 5'h00, b[2:0]});
    end
    $display("test routing done");
    conclude;
  end
endmodule
